/* shared/vsi_regs.vh */
/*
 * Register offsets, field positions, reset values and address-modifier
 * codes for the inbound slave image decoder.
 * Assumes byte offsets on a 12-bit register port with 32-bit data.
 */
// What this block does
// - claim when base <= address < bound
// - bound zero means no upper limit
// - destination address is source plus offset
// - image 4 fields use bits 31:12
// - image enable bit, resets to zero
// - posted write allow bit, resets zero
// - prefetch read allow bit, resets zero
// - program/data AM selector, resets to 11
// - privilege AM selector, resets to 11
// - space selector: A24, A32, User1, User2
// - wide local transfer allow, resets zero
// - lock on RMW allow, resets zero
// - local space: memory, I/O, configuration
// - only memory space cycles are decoupled
// - no claim without bus master allow
// - non-memory space forces posting, prefetch off
// - image 6 control mirrors image 5
// - image 4 also allows A16 space
`ifndef VSI_REGS_VH
`define VSI_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define OFS_IMG4_CTL      12'h0_F90
`define OFS_IMG4_BASE     12'h0_F94
`define OFS_IMG4_BOUND    12'h0_F98
`define OFS_IMG4_XLAT     12'h0_F9C
`define OFS_IMG5_CTL      12'h0_FA4
`define OFS_IMG5_BASE     12'h0_FA8
`define OFS_IMG5_BOUND    12'h0_FAC
`define OFS_IMG5_XLAT     12'h0_FB0
`define OFS_IMG6_CTL      12'h0_FB8
`define OFS_DEC_STATUS    12'h0_FD0

// ==========================================================
// control register fields
`define CTL_EN            31
`define CTL_POSTED_WRITE_ALLOW          30
`define CTL_PREFETCH_READ_ALLOW          29
`define CTL_PGM_HI        23
`define CTL_PGM_LO        22
`define CTL_PRIV_HI       21
`define CTL_PRIV_LO       20
`define CTL_SPACE_HI      18
`define CTL_SPACE_LO      16
`define CTL_WIDE          7
`define CTL_LOCK          6
`define CTL_LSPACE_HI     1
`define CTL_LSPACE_LO     0
`define CTL_MASK          32'hE0F7_00C3
`define CTL_RESET         32'h00F0_0000

// ==========================================================
// address field masks and reset values
`define IMG4_ADDR_MASK    32'hFFFF_F000
`define IMG5_ADDR_MASK    32'hFFFF_0000
`define ADDR_RESET        32'h0000_0000

// ==========================================================
// selector encodings
`define SPACE_A16         3'h0
`define SPACE_A24         3'h1
`define SPACE_A32         3'h2
`define SPACE_USER1       3'h6
`define SPACE_USER2       3'h7
`define LSPACE_MEM        2'h0
`define LSPACE_IO         2'h1
`define LSPACE_CFG        2'h2
`define AMSEL_DATA        2'h1
`define AMSEL_PROG        2'h2

// ==========================================================
// address-modifier code groups, am[5:3], and low-bit codes, am[1:0]
`define AM_GRP_A32        3'h1
`define AM_GRP_USER1      3'h2
`define AM_GRP_USER2      3'h3
`define AM_GRP_A16        3'h5
`define AM_GRP_A24        3'h7
`define AM_LOW_PROG       2'h2
`define AM_LOW_A16        2'h1

`endif

/* core/vme_slave_image_decode.v */
/*
 * Inbound slave image decoder: programmable images 4 and 5 claim
 * incoming bus cycles, translate the address and report the local
 * attributes; image 6 holds its control register only.
 * Assumes the cycle inputs and the bus master allow level come from
 * logic on i_core_clk, and a single-cycle register port master.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "vsi_regs.vh"

module vme_slave_image_decode (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // register port
  input  wire [11:0] i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  // local command register bit
  input  wire        i_bus_master_allow,
  // incoming cycle
  input  wire        i_cyc_valid,
  input  wire [31:0] i_cyc_addr,
  input  wire [5:0]  i_cyc_am,
  input  wire        i_cyc_write,
  input  wire        i_cyc_rmw,
  // decode result, one cycle later
  output reg         o_dec_valid,
  output reg         o_dec_hit,
  output reg  [2:0]  o_dec_image,
  output reg  [31:0] o_pci_addr,
  output reg  [1:0]  o_local_space,
  output reg         o_posted_write,
  output reg         o_prefetch_read,
  output reg         o_wide_transfer,
  output reg         o_bus_lock,
  output reg         o_decoupled
);

  // ==========================================================
  // registers and image fields
  wire [31:0] img4_ctl;
  wire [31:0] img4_base;
  wire [31:0] img4_bound;
  wire [31:0] img4_xlat;
  wire [31:0] img5_ctl;
  wire [31:0] img5_base;
  wire [31:0] img5_bound;
  wire [31:0] img5_xlat;
  reg  [31:0] img6_ctl_q;
  reg  [15:0] claim_count_q;
  reg  [15:0] miss_count_q;
  reg  [31:0] rdata_d;

  // ==========================================================
  // image register sets
  // image 4 keeps bits 31:12
  vsi_image_regs #(
    .OFS_CTL   (`OFS_IMG4_CTL),
    .OFS_BASE  (`OFS_IMG4_BASE),
    .OFS_BOUND (`OFS_IMG4_BOUND),
    .OFS_XLAT  (`OFS_IMG4_XLAT),
    .ADDR_MASK (`IMG4_ADDR_MASK)
  ) i_vsi_image_regs_4 (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_reg_addr  (i_reg_addr),
    .i_reg_wdata (i_reg_wdata),
    .i_reg_wr    (i_reg_wr),
    .o_ctl       (img4_ctl),
    .o_base      (img4_base),
    .o_bound     (img4_bound),
    .o_xlat      (img4_xlat)
  );

  vsi_image_regs #(
    .OFS_CTL   (`OFS_IMG5_CTL),
    .OFS_BASE  (`OFS_IMG5_BASE),
    .OFS_BOUND (`OFS_IMG5_BOUND),
    .OFS_XLAT  (`OFS_IMG5_XLAT),
    .ADDR_MASK (`IMG5_ADDR_MASK)
  ) i_vsi_image_regs_5 (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_reg_addr  (i_reg_addr),
    .i_reg_wdata (i_reg_wdata),
    .i_reg_wr    (i_reg_wr),
    .o_ctl       (img5_ctl),
    .o_base      (img5_base),
    .o_bound     (img5_bound),
    .o_xlat      (img5_xlat)
  );

  // ==========================================================
  // per-image claim
  wire        img4_hit;
  wire        img5_hit;
  wire        any_hit;
  wire [31:0] img4_dest;
  wire [31:0] img5_dest;
  wire [31:0] sel_ctl;
  wire [31:0] sel_dest;
  wire        sel_mem;

  vsi_image_match #(
    .ADDR_MASK (`IMG4_ADDR_MASK),
    .A16_OK    (1'b1)
  ) i_vsi_image_match_4 (
    .i_ctl              (img4_ctl),
    .i_base             (img4_base),
    .i_bound            (img4_bound),
    .i_xlat             (img4_xlat),
    .i_bus_master_allow (i_bus_master_allow),
    .i_cyc_addr         (i_cyc_addr),
    .i_cyc_am           (i_cyc_am),
    .o_hit              (img4_hit),
    .o_dest_addr        (img4_dest)
  );

  vsi_image_match #(
    .ADDR_MASK (`IMG5_ADDR_MASK),
    .A16_OK    (1'b0)
  ) i_vsi_image_match_5 (
    .i_ctl              (img5_ctl),
    .i_base             (img5_base),
    .i_bound            (img5_bound),
    .i_xlat             (img5_xlat),
    .i_bus_master_allow (i_bus_master_allow),
    .i_cyc_addr         (i_cyc_addr),
    .i_cyc_am           (i_cyc_am),
    .o_hit              (img5_hit),
    .o_dest_addr        (img5_dest)
  );

  assign any_hit  = img4_hit || img5_hit;

  // overlapping images: the lower numbered one wins
  assign sel_ctl  = img4_hit ? img4_ctl  : img5_ctl;
  assign sel_dest = img4_hit ? img4_dest : img5_dest;
  assign sel_mem  = (sel_ctl[`CTL_LSPACE_HI:`CTL_LSPACE_LO] == `LSPACE_MEM);

  // ==========================================================
  // decode result, registered
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dec_valid     <= 1'b0;
      o_dec_hit       <= 1'b0;
      o_dec_image     <= 3'h0;
      o_pci_addr      <= 32'h0000_0000;
      o_local_space   <= 2'h0;
      o_posted_write  <= 1'b0;
      o_prefetch_read <= 1'b0;
      o_wide_transfer <= 1'b0;
      o_bus_lock      <= 1'b0;
      o_decoupled     <= 1'b0;
    end else begin
      o_dec_valid <= i_cyc_valid;
      o_dec_hit   <= i_cyc_valid && any_hit;
      if (i_cyc_valid && any_hit) begin
        o_dec_image     <= img4_hit ? 3'h4 : 3'h5;
        o_pci_addr      <= sel_dest;
        o_local_space   <= sel_ctl[`CTL_LSPACE_HI:`CTL_LSPACE_LO];
        o_posted_write  <= sel_mem && sel_ctl[`CTL_POSTED_WRITE_ALLOW] && i_cyc_write;
        o_prefetch_read <= sel_mem && sel_ctl[`CTL_PREFETCH_READ_ALLOW] && !i_cyc_write;
        o_wide_transfer <= sel_ctl[`CTL_WIDE];
        o_bus_lock      <= sel_ctl[`CTL_LOCK] && i_cyc_rmw;
        o_decoupled     <= sel_mem && sel_ctl[`CTL_POSTED_WRITE_ALLOW] && i_cyc_write;
      end else begin
        o_dec_image     <= 3'h0;
        o_pci_addr      <= 32'h0000_0000;
        o_local_space   <= 2'h0;
        o_posted_write  <= 1'b0;
        o_prefetch_read <= 1'b0;
        o_wide_transfer <= 1'b0;
        o_bus_lock      <= 1'b0;
        o_decoupled     <= 1'b0;
      end
    end
  end

  // ==========================================================
  // claim and miss counters, saturating so they never wrap to look idle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      claim_count_q <= 16'h0000;
      miss_count_q  <= 16'h0000;
    end else if (i_reg_wr && (i_reg_addr == `OFS_DEC_STATUS)) begin
      claim_count_q <= 16'h0000;
      miss_count_q  <= 16'h0000;
    end else if (i_cyc_valid) begin
      if (any_hit && (claim_count_q != 16'hFFFF)) begin
        claim_count_q <= claim_count_q + 16'h0001;
      end
      if (!any_hit && (miss_count_q != 16'hFFFF)) begin
        miss_count_q <= miss_count_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // image 6 control; held only, it decodes nothing
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // image 6 control same layout and reset
      img6_ctl_q <= `CTL_RESET;
    end else if (i_reg_wr && (i_reg_addr == `OFS_IMG6_CTL)) begin
      img6_ctl_q <= i_reg_wdata & `CTL_MASK;
    end
  end

  // ==========================================================
  // read mux; unmapped offsets read zero
  always @* begin
    case (i_reg_addr)
      `OFS_IMG4_CTL:   rdata_d = img4_ctl;
      `OFS_IMG4_BASE:  rdata_d = img4_base;
      `OFS_IMG4_BOUND: rdata_d = img4_bound;
      `OFS_IMG4_XLAT:  rdata_d = img4_xlat;
      `OFS_IMG5_CTL:   rdata_d = img5_ctl;
      `OFS_IMG5_BASE:  rdata_d = img5_base;
      `OFS_IMG5_BOUND: rdata_d = img5_bound;
      `OFS_IMG5_XLAT:  rdata_d = img5_xlat;
      `OFS_IMG6_CTL:   rdata_d = img6_ctl_q;
      `OFS_DEC_STATUS: rdata_d = {miss_count_q, claim_count_q};
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==========================================================
// one decoding image: address-modifier filter, range check and
// translation; repeats per image with its own granularity
module vsi_image_match #(
  parameter [31:0] ADDR_MASK = `IMG4_ADDR_MASK,
  parameter [0:0]  A16_OK    = 1'b0
) (
  // image fields
  input  wire [31:0] i_ctl,
  input  wire [31:0] i_base,
  input  wire [31:0] i_bound,
  input  wire [31:0] i_xlat,
  // incoming cycle
  input  wire        i_bus_master_allow,
  input  wire [31:0] i_cyc_addr,
  input  wire [5:0]  i_cyc_am,
  // claim and destination
  output wire        o_hit,
  output wire [31:0] o_dest_addr
);

  wire [2:0]  space;
  wire [2:0]  am_grp;
  wire        prog;
  wire        pgm_ok;
  wire        priv_ok;
  wire [31:0] addr_m;
  wire [31:0] base_m;
  wire [31:0] bound_m;
  wire        above_base;
  wire        below_bound;
  reg         space_ok;

  assign space  = i_ctl[`CTL_SPACE_HI:`CTL_SPACE_LO];
  assign am_grp = i_cyc_am[5:3];
  assign prog   = (i_cyc_am[1:0] == `AM_LOW_PROG);

  // space selector decode, reserved codes never match
  always @* begin
    case (space)
      `SPACE_A16:   space_ok = A16_OK && (am_grp == `AM_GRP_A16) && (i_cyc_am[1:0] == `AM_LOW_A16);
      `SPACE_A24:   space_ok = (am_grp == `AM_GRP_A24);
      `SPACE_A32:   space_ok = (am_grp == `AM_GRP_A32);
      `SPACE_USER1: space_ok = (am_grp == `AM_GRP_USER1);
      `SPACE_USER2: space_ok = (am_grp == `AM_GRP_USER2);
      default:      space_ok = 1'b0;
    endcase
  end

  assign pgm_ok  = prog ? i_ctl[`CTL_PGM_HI] : i_ctl[`CTL_PGM_LO];
  // privilege filter, am bit 2 marks supervisor
  assign priv_ok = i_cyc_am[2] ? i_ctl[`CTL_PRIV_HI] : i_ctl[`CTL_PRIV_LO];

  // bits below the image granularity take no part in the compare
  assign addr_m  = i_cyc_addr & ADDR_MASK;
  assign base_m  = i_base & ADDR_MASK;
  assign bound_m = i_bound & ADDR_MASK;
  assign above_base  = (addr_m >= base_m);
  // zero bound lifts the upper limit
  assign below_bound = (bound_m == 32'h0000_0000) || (addr_m < bound_m);

  assign o_hit = i_bus_master_allow && i_ctl[`CTL_EN] && space_ok && pgm_ok && priv_ok &&
                 above_base && below_bound;

  assign o_dest_addr = i_cyc_addr + (i_xlat & ADDR_MASK);

endmodule

// ==========================================================
// register set of one decoding image; reserved bits never stored
module vsi_image_regs #(
  parameter [11:0] OFS_CTL   = `OFS_IMG4_CTL,
  parameter [11:0] OFS_BASE  = `OFS_IMG4_BASE,
  parameter [11:0] OFS_BOUND = `OFS_IMG4_BOUND,
  parameter [11:0] OFS_XLAT  = `OFS_IMG4_XLAT,
  parameter [31:0] ADDR_MASK = `IMG4_ADDR_MASK
) (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // register port
  input  wire [11:0] i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  // stored fields
  output reg  [31:0] o_ctl,
  output reg  [31:0] o_base,
  output reg  [31:0] o_bound,
  output reg  [31:0] o_xlat
);

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl   <= `CTL_RESET;
      o_base  <= `ADDR_RESET;
      o_bound <= `ADDR_RESET;
      o_xlat  <= `ADDR_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == OFS_CTL) begin
        o_ctl <= i_reg_wdata & `CTL_MASK;
      end
      if (i_reg_addr == OFS_BASE) begin
        o_base <= i_reg_wdata & ADDR_MASK;
      end
      if (i_reg_addr == OFS_BOUND) begin
        o_bound <= i_reg_wdata & ADDR_MASK;
      end
      if (i_reg_addr == OFS_XLAT) begin
        o_xlat <= i_reg_wdata & ADDR_MASK;
      end
    end
  end

endmodule

/* testbench/vsi_dec_monitor.sv */
/* port checker for the slave image decoder.
   assumes one clock, async active-high reset, bound to the decoder. */
`timescale 1ns/1ps
module vsi_dec_monitor (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // incoming cycle
  input wire logic        i_bus_master_allow,
  input wire logic        i_cyc_valid,
  input wire logic        i_cyc_write,
  input wire logic        i_cyc_rmw,
  // decode result
  input wire logic        o_dec_valid,
  input wire logic        o_dec_hit,
  input wire logic [2:0]  o_dec_image,
  input wire logic [31:0] o_pci_addr,
  input wire logic [1:0]  o_local_space,
  input wire logic        o_posted_write,
  input wire logic        o_prefetch_read,
  input wire logic        o_bus_lock,
  input wire logic        o_decoupled
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ======
  // decode properties
  sequence s_req; i_cyc_valid; endsequence
  sequence s_claim; o_dec_valid && o_dec_hit; endsequence
  property p_answer; s_req |=> o_dec_valid; endproperty
  a_answer: assert property (p_answer) else $error("decode answer missing");
  property p_quiet; !i_cyc_valid |=> !o_dec_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("decode answer without cycle");
  property p_master; i_cyc_valid && !i_bus_master_allow |=> !o_dec_hit; endproperty
  a_master: assert property (p_master) else $error("claim without bus master allow");
  property p_image; s_claim |-> o_dec_image == 3'h4 || o_dec_image == 3'h5; endproperty
  a_image: assert property (p_image) else $error("claim by wrong image");
  property p_miss; o_dec_valid && !o_dec_hit |-> o_pci_addr == 32'h0000_0000 && !o_posted_write; endproperty
  a_miss: assert property (p_miss) else $error("miss carries attributes");
  property p_nonmem; s_claim ##0 o_local_space != 2'h0 |-> !o_posted_write && !o_prefetch_read; endproperty
  a_nonmem: assert property (p_nonmem) else $error("posting or prefetch outside memory");
  property p_decouple; o_decoupled |-> o_local_space == 2'h0 && $past(i_cyc_write); endproperty
  a_decouple: assert property (p_decouple) else $error("decoupled non-memory cycle");
  property p_lock; o_bus_lock |-> $past(i_cyc_rmw); endproperty
  a_lock: assert property (p_lock) else $error("lock without rmw");
  property p_prefetch; o_prefetch_read |-> !$past(i_cyc_write); endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch on a write");
endmodule
bind vme_slave_image_decode vsi_dec_monitor i_vsi_dec_monitor (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_bus_master_allow(i_bus_master_allow), .i_cyc_valid(i_cyc_valid), .i_cyc_write(i_cyc_write),
  .i_cyc_rmw(i_cyc_rmw), .o_dec_valid(o_dec_valid), .o_dec_hit(o_dec_hit), .o_dec_image(o_dec_image),
  .o_pci_addr(o_pci_addr), .o_local_space(o_local_space), .o_posted_write(o_posted_write),
  .o_prefetch_read(o_prefetch_read), .o_bus_lock(o_bus_lock), .o_decoupled(o_decoupled));

/* testbench/vme_master_model.sv */
/* far-side bus master model presenting one cycle at a time.
   assumes the decoder takes a cycle at a rising edge with valid high. */
`timescale 1ns/1ps
module vme_master_model (
  // clock
  input  wire logic        i_core_clk,
  // cycle to the decoder
  output logic        o_valid,
  output logic [31:0] o_addr,
  output logic [5:0]  o_am,
  output logic        o_write,
  output logic        o_rmw
);
  initial begin
    o_valid = 1'b0;
    o_addr  = 32'h0000_0000;
    o_am    = 6'h00;
    o_write = 1'b0;
    o_rmw   = 1'b0;
  end
  // ======
  // cycle task
  task automatic issue(input logic [31:0] a, input logic [5:0] am, input logic w, input logic m);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_addr  <= a;
    o_am    <= am;
    o_write <= w;
    o_rmw   <= m;
    @(posedge i_core_clk);
    // released lines flip so stale values cannot pass
    o_valid <= 1'b0;
    o_addr  <= ~a;
    o_am    <= ~am;
    o_write <= ~w;
    o_rmw   <= ~m;
  endtask
endmodule

/* testbench/vme_slave_image_decode_tb.sv */
/* self-checking bench for the slave image decoder.
   assumes the register map header and the master model beside it. */
`timescale 1ns/1ps
`include "vsi_regs.vh"
module vme_slave_image_decode_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] ra = 12'h0_000;
  logic [31:0] wd = 32'h0000_0000;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        bma = 1'b0;
  logic [31:0] rdata, pci, ca;
  logic        dv, hit, pw, pr, wide, lock, dec, cv, cw, cm;
  logic [2:0]  img;
  logic [1:0]  ls;
  logic [5:0]  cam;
  int          n_errors = 0;
  int          n_tests = 0;
  logic [11:0] ofs [9] = '{12'h0_F90, 12'h0_FA4, 12'h0_FB8, 12'h0_F94, 12'h0_F98, 12'h0_F9C, 12'h0_FA8,
                           12'h0_FAC, 12'h0_FB0};
  logic [31:0] actl [4] = '{32'hE072_00C0, 32'hE0B2_00C0, 32'hE0D2_00C0, 32'hE0E2_00C0};
  logic [5:0]  arej [4] = '{6'h0E, 6'h0D, 6'h0D, 6'h09};
  logic [5:0]  aacc [4] = '{6'h0D, 6'h0E, 6'h09, 6'h0D};
  logic [2:0]  sp [4] = '{3'h1, 3'h2, 3'h6, 3'h7};
  logic [5:0]  sam [4] = '{6'h3D, 6'h0D, 6'h15, 6'h1D};

  vme_master_model i_vme_master_model (.i_core_clk(clk), .o_valid(cv), .o_addr(ca), .o_am(cam),
    .o_write(cw), .o_rmw(cm));
  vme_slave_image_decode i_vme_slave_image_decode (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(we), .i_reg_rd(re), .o_reg_rdata(rdata), .i_bus_master_allow(bma),
    .i_cyc_valid(cv), .i_cyc_addr(ca), .i_cyc_am(cam), .i_cyc_write(cw), .i_cyc_rmw(cm),
    .o_dec_valid(dv), .o_dec_hit(hit), .o_dec_image(img), .o_pci_addr(pci), .o_local_space(ls),
    .o_posted_write(pw), .o_prefetch_read(pr), .o_wide_transfer(wide), .o_bus_lock(lock),
    .o_decoupled(dec));

  always #5 clk = ~clk;

  // ======
  // tasks
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk("register", rdata, e);
  endtask
  // e packs valid, hit, image, posted, prefetch, wide, lock, decoupled
  task dc(input logic [31:0] a, input logic [5:0] am, input logic w, input logic m,
          input logic [9:0] e, input logic [31:0] p, input logic [1:0] s);
    i_vme_master_model.issue(a, am, w, m);
    #1 chk("attributes", {22'h00_0000, dv, hit, img, pw, pr, wide, lock, dec}, {22'h00_0000, e});
    chk("pci address", pci, p);
    if (e[8])
      chk("local space", {30'h0000_0000, ls}, {30'h0000_0000, s});
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #200_000;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd(ofs[i], i < 3 ? `CTL_RESET : `ADDR_RESET);
    rd(12'h0_F00, 32'h0000_0000);
    $display("test reset done");
    wr(12'h0_FA4, 32'hFFFF_FFFF);
    rd(12'h0_FA4, `CTL_MASK);
    wr(12'h0_FB8, 32'hFFFF_FFFF);
    rd(12'h0_FB8, `CTL_MASK);
    wr(12'h0_FA4, `CTL_RESET);
    wr(12'h0_F94, 32'h1000_0ABC);
    rd(12'h0_F94, 32'h1000_0000);
    wr(12'h0_FA8, 32'h0012_FFFF);
    rd(12'h0_FA8, 32'h0012_0000);
    wr(12'h0_F9C, 32'hF000_0FFF);
    rd(12'h0_F9C, 32'hF000_0000);
    $display("test fields done");
    wr(12'h0_F98, 32'h1000_3000);
    wr(12'h0_F90, 32'hE0F2_00C0);
    bma <= 1'b1;
    dc(32'h1000_0000, 6'h0D, 1'b1, 1'b0, 10'h395, 32'h0000_0000, 2'h0);
    dc(32'h1000_2FFC, 6'h0D, 1'b0, 1'b1, 10'h38E, 32'h0000_2FFC, 2'h0);
    dc(32'h1000_3000, 6'h0D, 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    dc(32'h0FFF_FFFC, 6'h0D, 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    dc(32'h1000_0000, 6'h3D, 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    bma <= 1'b0;
    dc(32'h1000_0000, 6'h0D, 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    bma <= 1'b1;
    wr(12'h0_F98, 32'h0000_0000);
    dc(32'hFFFF_FFFC, 6'h0D, 1'b1, 1'b0, 10'h395, 32'hEFFF_FFFC, 2'h0);
    $display("test range done");
    for (int i = 0; i < 4; i++) begin
      wr(12'h0_F90, actl[i]);
      dc(32'h1000_0000, arej[i], 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
      dc(32'h1000_0000, aacc[i], 1'b1, 1'b0, 10'h395, 32'h0000_0000, 2'h0);
    end
    for (int s = 1; s < 3; s++) begin
      wr(12'h0_F90, 32'hE0F2_00C0 + s);
      dc(32'h1000_0000, 6'h0D, 1'b1, 1'b0, 10'h384, 32'h0000_0000, s[1:0]);
      dc(32'h1000_0000, 6'h0D, 1'b0, 1'b1, 10'h386, 32'h0000_0000, s[1:0]);
    end
    $display("test selectors done");
    wr(12'h0_F94, 32'h0000_0000);
    wr(12'h0_F98, 32'h0000_2000);
    wr(12'h0_F90, 32'hE0F0_00C0);
    dc(32'h0000_1234, 6'h2D, 1'b1, 1'b0, 10'h395, 32'hF000_1234, 2'h0);
    dc(32'h0000_2000, 6'h2D, 1'b1, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    wr(12'h0_F90, `CTL_RESET);
    wr(12'h0_FAC, 32'h0014_0000);
    wr(12'h0_FB0, 32'h0100_1234);
    rd(12'h0_FB0, 32'h0100_0000);
    for (int j = 0; j < 4; j++) begin
      wr(12'h0_FA4, 32'h80F0_0000 | {13'h0000, sp[j], 16'h0000});
      dc(32'h0013_4567, sam[j], 1'b0, 1'b0, 10'h3A0, 32'h0113_4567, 2'h0);
    end
    dc(32'h0014_0000, 6'h1D, 1'b0, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    dc(32'h0011_FFFC, 6'h1D, 1'b0, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    wr(12'h0_FA4, 32'h00F7_0000);
    dc(32'h0013_4567, 6'h1D, 1'b0, 1'b0, 10'h200, 32'h0000_0000, 2'h0);
    $display("test image 5 done");
    summarize();
  end
endmodule
